// file: rtl/drive_stop_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module drive_stop_sequencer import stop_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic COAST_STOP_N,
  input wire logic DRIVE_ENABLE,
  input wire logic PROGRAM_STOP_N,
  input wire logic RUN_STOP,
  input wire logic [15:0] SPEED,
  output logic POWER_STAGE_EN,
  output logic CONTACTOR_PILOT,
  output logic LOOPS_RESET,
  output logic RAMP_TO_ZERO,
  output logic [15:0] RAMP_TIME,
  output logic [15:0] CURRENT_LIMIT
);
  ////////////////////////////////////////////////////////////////////////
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic prog_prev_q;
  logic run_prev_q;
  logic coast_s;
  logic enable_s;
  logic prog_s;
  logic run_s;
  logic prog_fall;
  logic run_rise;

  // Two-stage synchronisers for terminal inputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync1_q <= 4'h7;
      sync2_q <= 4'h7;
      prog_prev_q <= 1'b1;
      run_prev_q <= 1'b0;
    end else begin
      sync1_q <= {RUN_STOP, PROGRAM_STOP_N, DRIVE_ENABLE, COAST_STOP_N};
      sync2_q <= sync1_q;
      prog_prev_q <= sync2_q[2];
      run_prev_q <= sync2_q[3];
    end
  end

  assign coast_s = !sync2_q[0];
  assign enable_s = sync2_q[1];
  assign prog_s = sync2_q[2];
  assign run_s = sync2_q[3];
  assign prog_fall = prog_prev_q && !prog_s;
  assign run_rise = run_s && !run_prev_q;

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] cfg_q [NUM_CFG];
  logic [31:0] status;
  logic bus_req;
  logic cfg_hit;

  // Classic Wishbone slave, one wait state, unmapped reads zero
  assign bus_req = CYC_I && STB_I && !ACK_O;
  assign cfg_hit = (ADR_I[1:0] == 2'h0) && (ADR_I <= OFS_CFG_LAST);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0;
    end else begin
      ACK_O <= bus_req;
      DAT_O <= 32'h0;
      if (bus_req && !WE_I) begin
        if (cfg_hit) begin
          DAT_O <= {16'h0, cfg_q[ADR_I[4:2]]};
        end else if (ADR_I == OFS_STATUS) begin
          DAT_O <= status;
        end
      end
    end
  end

  // Configuration storage, byte lanes 0 and 1
  generate
    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          cfg_q[i] <= CFG_RESET[i];
        end else if (bus_req && WE_I && cfg_hit && ADR_I[4:2] == 3'(i)) begin
          if (SEL_I[0]) begin
            cfg_q[i][7:0] <= DAT_I[7:0];
          end
          if (SEL_I[1]) begin
            cfg_q[i][15:8] <= DAT_I[15:8];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] pres_q;
  logic tick_q;
  logic [15:0] limit_cfg;
  timer_if #(.W(TIMER_W)) limit_t ();
  timer_if #(.W(TIMER_W)) delay_t ();

  // Millisecond tick for both timers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pres_q <= 16'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pres_q == 16'(MS_TICK_CYCLES - 1));
      if (pres_q == 16'(MS_TICK_CYCLES - 1)) begin
        pres_q <= 16'h0;
      end else begin
        pres_q <= pres_q + 16'h1;
      end
    end
  end

  stop_timer #(.W(TIMER_W)) u_limit (
    .clk(CLK),
    .rst(SYS_RST),
    .t(limit_t)
  );

  stop_timer #(.W(TIMER_W)) u_delay (
    .clk(CLK),
    .rst(SYS_RST),
    .t(delay_t)
  );

  ////////////////////////////////////////////////////////////////////////
  seq_state_e state_q;
  seq_state_e state_d;
  logic prog_latch_q;
  logic [15:0] zero_lvl;
  logic at_zero;
  logic jog;

  // Active zero level follows the stop flavour
  assign zero_lvl = prog_latch_q ? cfg_q[CFG_ZERO_PROG] : cfg_q[CFG_ZERO_NORM];
  assign at_zero = SPEED <= zero_lvl;
  assign jog = zero_lvl < JOG_ZERO_LEVEL;
  assign limit_cfg = (cfg_q[CFG_PROG_LIMIT] > LIMIT_MAX) ? LIMIT_MAX :
                     cfg_q[CFG_PROG_LIMIT];

  // Timer control
  assign limit_t.tick = tick_q;
  assign limit_t.start = prog_fall;
  assign limit_t.stop = (state_d == ST_IDLE) || (state_d == ST_COAST);
  assign limit_t.load = TIMER_W'(limit_cfg) * TIMER_W'(LIMIT_UNIT_MS);
  assign delay_t.tick = tick_q;
  assign delay_t.start = (state_d == ST_CONT_DELAY) &&
                         (state_q != ST_CONT_DELAY);
  assign delay_t.stop = state_d != ST_CONT_DELAY;
  assign delay_t.load = {7'h00, cfg_q[CFG_CONT_DELAY]};

  // Program stop latch; a new fall wins over the clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      prog_latch_q <= 1'b0;
    end else if (prog_fall) begin
      prog_latch_q <= 1'b1;
    end else if (prog_s && (state_q == ST_IDLE || state_q == ST_COAST)) begin
      prog_latch_q <= 1'b0;
    end
  end

  // Next state with fixed stop priority
  always_comb begin
    state_d = state_q;
    if (coast_s || limit_t.expired) begin
      state_d = ST_COAST;
    end else if (!enable_s && state_q != ST_COAST && state_q != ST_IDLE) begin
      state_d = ST_DISABLED;
    end else begin
      unique case (state_q)
        ST_COAST: begin
          if (!run_s) state_d = ST_IDLE;
        end
        ST_IDLE: begin
          if (run_rise && enable_s && prog_s && !prog_latch_q) begin
            state_d = ST_RUN;
          end
        end
        ST_DISABLED: begin
          if (prog_latch_q) state_d = ST_PROG_STOP;
          else if (run_s) state_d = ST_RUN;
          else state_d = ST_NORM_STOP;
        end
        ST_RUN: begin
          if (prog_latch_q) state_d = ST_PROG_STOP;
          else if (!run_s) state_d = ST_NORM_STOP;
        end
        ST_NORM_STOP: begin
          if (prog_latch_q) state_d = ST_PROG_STOP;
          else if (run_s) state_d = ST_RUN;
          else if (at_zero) state_d = ST_CONT_DELAY;
        end
        ST_PROG_STOP: begin
          if (at_zero) state_d = ST_CONT_DELAY;
        end
        ST_CONT_DELAY: begin
          if (delay_t.expired) state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // Drive outputs decoded from the next state
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      POWER_STAGE_EN <= 1'b0;
      CONTACTOR_PILOT <= 1'b0;
      LOOPS_RESET <= 1'b1;
      RAMP_TO_ZERO <= 1'b0;
    end else begin
      POWER_STAGE_EN <= (state_d == ST_RUN) || (state_d == ST_NORM_STOP) ||
                        (state_d == ST_PROG_STOP) ||
                        (state_d == ST_CONT_DELAY && jog);
      CONTACTOR_PILOT <= !(state_d == ST_IDLE || state_d == ST_COAST);
      LOOPS_RESET <= (state_d == ST_IDLE) || (state_d == ST_COAST) ||
                     (state_d == ST_DISABLED);
      RAMP_TO_ZERO <= (state_d == ST_NORM_STOP) || (state_d == ST_PROG_STOP) ||
                      (state_d == ST_CONT_DELAY);
    end
  end

  // Ramp time and current limit selected by stop flavour
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RAMP_TIME <= RST_RAMP_NORM;
      CURRENT_LIMIT <= RST_ILIM_NORM;
    end else begin
      RAMP_TIME <= prog_latch_q ? cfg_q[CFG_RAMP_PROG] : cfg_q[CFG_RAMP_NORM];
      CURRENT_LIMIT <= prog_latch_q ? cfg_q[CFG_ILIM_PROG] :
                       cfg_q[CFG_ILIM_NORM];
    end
  end

  // Status word
  always_comb begin
    status = 32'h0;
    status[STAT_STATE_LSB +: 7] = state_q;
    status[STAT_LATCH_BIT] = prog_latch_q;
    status[STAT_LIMIT_BIT] = limit_t.busy;
    status[STAT_DELAY_BIT] = delay_t.busy;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  coast_opens_a: assert property (coast_s |=> !POWER_STAGE_EN && !CONTACTOR_PILOT) else $error("coast stop left drive on");
  enable_hold_a: assert property ((!enable_s && !coast_s && !limit_t.expired && state_q == ST_RUN) |=> LOOPS_RESET && !POWER_STAGE_EN && CONTACTOR_PILOT) else $error("enable removal mishandled");
  prog_select_a: assert property (prog_latch_q |=> CURRENT_LIMIT == $past(cfg_q[CFG_ILIM_PROG]) && RAMP_TIME == $past(cfg_q[CFG_RAMP_PROG])) else $error("program stop values not selected");
  run_refused_a: assert property ((state_q == ST_IDLE && run_rise && (coast_s || !prog_s || prog_latch_q)) |=> state_q != ST_RUN) else $error("run accepted during stop");
  jog_enable_a: assert property ((state_d == ST_CONT_DELAY) |=> POWER_STAGE_EN == $past(jog)) else $error("contactor delay enable wrong");
  prog_latch_a: assert property (prog_fall ##1 (prog_s && state_q != ST_IDLE && state_q != ST_COAST) [*2] |-> prog_latch_q) else $error("program stop latch lost");
  limit_start_a: assert property (prog_fall |=> limit_t.busy) else $error("limit timer not started");
  limit_quench_a: assert property (limit_t.expired |=> state_q == ST_COAST ##1 !CONTACTOR_PILOT) else $error("limit expiry did not coast");
  delay_open_a: assert property ((state_q == ST_CONT_DELAY && delay_t.expired && enable_s && !coast_s && !limit_t.expired) |=> !CONTACTOR_PILOT && state_q == ST_IDLE) else $error("contactor not opened after delay");
  zero_start_a: assert property ((state_q == ST_PROG_STOP && at_zero && enable_s && !coast_s && !limit_t.expired) |=> state_q == ST_CONT_DELAY ##1 delay_t.busy) else $error("contactor delay not started");
  priority_a: assert property ((coast_s && !enable_s && prog_latch_q) |=> state_q == ST_COAST) else $error("stop priority wrong");

  normal_stop_c: cover property (state_q == ST_NORM_STOP ##[1:1000] state_q == ST_IDLE);
  prog_stop_c: cover property (state_q == ST_PROG_STOP ##[1:1000] state_q == ST_CONT_DELAY);
  quench_c: cover property (limit_t.expired);
  disable_c: cover property (state_q == ST_DISABLED ##1 state_q == ST_RUN);
endmodule
`default_nettype wire

// file: shared/stop_pkg.sv
package stop_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  // Time limit unit is 0.1 s, counted in ms ticks
  localparam int LIMIT_UNIT_MS = 100;
  localparam logic [15:0] LIMIT_MAX = 16'h1770;   // 600.0 s
  localparam int TIMER_W = 23;
  // Speed and levels in 0.01 % units
  localparam logic [15:0] SPEED_FULL = 16'h2710;  // 100.00 %
  localparam logic [15:0] JOG_ZERO_LEVEL = 16'h0019; // 0.25 %

  // Configuration register indices and byte offsets
  localparam int NUM_CFG = 8;
  localparam logic [2:0] CFG_RAMP_NORM = 3'h0;
  localparam logic [2:0] CFG_RAMP_PROG = 3'h1;
  localparam logic [2:0] CFG_ILIM_NORM = 3'h2;
  localparam logic [2:0] CFG_ILIM_PROG = 3'h3;
  localparam logic [2:0] CFG_ZERO_NORM = 3'h4;
  localparam logic [2:0] CFG_ZERO_PROG = 3'h5;
  localparam logic [2:0] CFG_CONT_DELAY = 3'h6;
  localparam logic [2:0] CFG_PROG_LIMIT = 3'h7;
  localparam logic [7:0] OFS_CFG_LAST = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Reset values
  localparam logic [15:0] RST_RAMP_NORM = 16'h0064;
  localparam logic [15:0] RST_RAMP_PROG = 16'h0032;
  localparam logic [15:0] RST_ILIM_NORM = 16'h2710;
  localparam logic [15:0] RST_ILIM_PROG = 16'h2EE0;
  localparam logic [15:0] RST_ZERO_NORM = 16'h0064;
  localparam logic [15:0] RST_ZERO_PROG = 16'h0064;
  localparam logic [15:0] RST_CONT_DELAY = 16'h03E8;
  localparam logic [15:0] RST_PROG_LIMIT = 16'h0064;
  localparam logic [15:0] CFG_RESET [NUM_CFG] = '{RST_RAMP_NORM,
    RST_RAMP_PROG, RST_ILIM_NORM, RST_ILIM_PROG, RST_ZERO_NORM,
    RST_ZERO_PROG, RST_CONT_DELAY, RST_PROG_LIMIT};

  // Sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_RUN = 7'b0000010,
    ST_NORM_STOP = 7'b0000100,
    ST_PROG_STOP = 7'b0001000,
    ST_CONT_DELAY = 7'b0010000,
    ST_DISABLED = 7'b0100000,
    ST_COAST = 7'b1000000
  } seq_state_e;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LATCH_BIT = 7;
  localparam int STAT_LIMIT_BIT = 8;
  localparam int STAT_DELAY_BIT = 9;
endpackage

// file: shared/timer_if.sv
`timescale 1ns/100ps
`default_nettype none
interface timer_if #(parameter int W = 23);
  logic tick;
  logic start;
  logic stop;
  logic [W-1:0] load;
  logic expired;
  logic busy;
  modport owner(output tick, start, stop, load, input expired, busy);
  modport timer(input tick, start, stop, load, output expired, busy);
endinterface
`default_nettype wire

// file: rtl/stop_timer.sv
`timescale 1ns/100ps
`default_nettype none
module stop_timer #(parameter int W = 23) (
  input wire logic clk,
  input wire logic rst,
  timer_if.timer t
);
  logic [W-1:0] cnt_q;
  logic busy_q;
  logic expired_q;

  // Countdown in ticks; start wins over stop
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      if (t.start) begin
        cnt_q <= t.load;
        busy_q <= 1'b1;
      end else if (t.stop) begin
        busy_q <= 1'b0;
      end else if (busy_q && t.tick) begin
        if (cnt_q <= W'(1)) begin
          busy_q <= 1'b0;
          expired_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end

  assign t.busy = busy_q;
  assign t.expired = expired_q;
endmodule
`default_nettype wire

// file: sim/motor_model.sv
`timescale 1ns/100ps
`default_nettype none
module motor_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_en,
  input wire logic ramp_zero,
  input wire logic [15:0] step,
  output logic [15:0] speed
);
  // Speed climbs while driven, falls by step while stopping; step 0 stalls
  always_ff @(posedge clk) begin
    if (rst) begin
      speed <= 16'h0000;
    end else if (power_en && !ramp_zero) begin
      speed <= (speed > 16'h2610) ? 16'h2710 : speed + 16'h0100;
    end else begin
      speed <= (speed > step) ? speed - step : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: sim/drive_stop_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module drive_stop_sequencer_tb_top import stop_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic coast_n = 1'b1;
  logic enable = 1'b1;
  logic prog_n = 1'b1;
  logic run = 1'b0;
  logic [15:0] step = 16'h0200;
  logic [31:0] rdat;
  logic ack, power, pilot, loops_rst, ramp0;
  logic [15:0] speed, ramp_time, ilim;
  logic [31:0] exp_q [$];
  logic [31:0] rnd = 32'h9B6D;
  logic [15:0] lv [2] = '{16'h0064, 16'h0010};
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n, k;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and motor
  always #25 clk = ~clk;
  drive_stop_sequencer #(.MS_TICK_CYCLES(4)) uut (.CLK(clk), .SYS_RST(rst),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .DAT_I(wdat),
    .SEL_I(sel), .DAT_O(rdat), .ACK_O(ack), .COAST_STOP_N(coast_n),
    .DRIVE_ENABLE(enable), .PROGRAM_STOP_N(prog_n), .RUN_STOP(run),
    .SPEED(speed), .POWER_STAGE_EN(power), .CONTACTOR_PILOT(pilot),
    .LOOPS_RESET(loops_rst), .RAMP_TO_ZERO(ramp0), .RAMP_TIME(ramp_time),
    .CURRENT_LIMIT(ilim));
  motor_model mdl (.clk(clk), .rst(rst), .power_en(power),
    .ramp_zero(ramp0), .step(step), .speed(speed));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // Power, pilot, loop reset compared under a mask
  task automatic chk_out(input logic [2:0] e, input logic [2:0] m);
    num_checks++;
    if (({power, pilot, loops_rst} & m) !== (e & m)) begin
      bad_count++;
      $display("BAD outputs expected %b seen %b", e & m,
               {power, pilot, loops_rst} & m);
    end
  endtask
  // Classic single cycle; read expectations go to the queue
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    if (!w) exp_q.push_back(e);
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_full();
    for (n = 0; n < 300 && speed !== SPEED_FULL; n++) @(posedge clk);
  endtask
  task automatic wait_pilot(output int c);
    for (c = 0; c < 3000 && pilot !== 1'b0; c++) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read watcher: oldest note against data at the acknowledging edge
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      chk("read data", exp_q.pop_front(), rdat);
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_CFG; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0, {16'h0, CFG_RESET[i]});
    end
    bus(1'b0, OFS_STATUS, 32'h0, {25'h0, ST_IDLE});
    rnd = lfsr(rnd);
    bus(1'b1, 8'h24, rnd, 32'h0);
    bus(1'b0, 8'h24, 32'h0, 32'h0);
    bus(1'b1, 8'h00, rnd, 32'h0);
    bus(1'b0, 8'h00, 32'h0, {16'h0, rnd[15:0]});
    bus(1'b1, 8'h1C, 32'hFFFF, 32'h0);
    bus(1'b0, 8'h1C, 32'h0, 32'h0000FFFF);
    bus(1'b1, 8'h1C, 32'h1, 32'h0);
    bus(1'b1, 8'h18, 32'h5, 32'h0);
    chk_out(3'b001, 3'b111);
    $display("test registers done");
    // Normal stop at a plain and a jog zero level
    foreach (lv[i]) begin
      bus(1'b1, 8'h10, {16'h0, lv[i]}, 32'h0);
      run <= 1'b1;
      wait_full();
      chk_out(3'b110, 3'b111);
      run <= 1'b0;
      repeat (4) @(posedge clk);
      chk("ramp time", {16'h0, rnd[15:0]}, {16'h0, ramp_time});
      chk("current limit", {16'h0, RST_ILIM_NORM}, {16'h0, ilim});
      for (n = 0; n < 300 && speed > lv[i]; n++) @(posedge clk);
      repeat (4) @(posedge clk);
      chk_out({lv[i] < JOG_ZERO_LEVEL, 2'b10}, 3'b110);
      wait_pilot(k);
      chk("delay wait", 32'h1, {31'h0, k > 13 && k < 20});
      chk_out(3'b001, 3'b111);
      $display("test normal stop done");
    end
    // Program stop pulse with a stalled motor runs into the limit
    run <= 1'b1;
    wait_full();
    step <= 16'h0000;
    prog_n <= 1'b0;
    repeat (3) @(posedge clk);
    prog_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ramp time", {16'h0, RST_RAMP_PROG}, {16'h0, ramp_time});
    chk("current limit", {16'h0, RST_ILIM_PROG}, {16'h0, ilim});
    chk("ramp to zero", 32'h1, {31'h0, ramp0});
    chk_out(3'b110, 3'b110);
    wait_pilot(k);
    chk("limit wait", 32'h1, {31'h0, k > 380 && k < 400});
    chk_out(3'b000, 3'b110);
    run <= 1'b0;
    step <= 16'h0200;
    repeat (20) @(posedge clk);
    $display("test program stop done");
    // Run raised during coast stays refused
    coast_n <= 1'b0;
    run <= 1'b1;
    repeat (8) @(posedge clk);
    chk_out(3'b000, 3'b110);
    run <= 1'b0;
    coast_n <= 1'b1;
    repeat (6) @(posedge clk);
    run <= 1'b1;
    wait_full();
    chk_out(3'b110, 3'b111);
    $display("test refused run done");
    // Enable over program stop, then coast over all
    enable <= 1'b0;
    prog_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk_out(3'b011, 3'b111);
    chk_out(3'b011, 3'b111);
    coast_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk_out(3'b000, 3'b110);
    chk_out(3'b000, 3'b110);
    coast_n <= 1'b1;
    enable <= 1'b1;
    prog_n <= 1'b1;
    run <= 1'b0;
    repeat (20) @(posedge clk);
    $display("test priority done");
    // Program stop pulse with a moving motor reaches zero speed
    run <= 1'b1;
    wait_full();
    prog_n <= 1'b0;
    repeat (3) @(posedge clk);
    prog_n <= 1'b1;
    for (n = 0; n < 300 && speed > RST_ZERO_PROG; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk_out(3'b010, 3'b110);
    wait_pilot(k);
    chk("prog delay wait", 32'h1, {31'h0, k > 13 && k < 20});
    chk_out(3'b001, 3'b111);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    $display("test program stop to zero done");
    print_verdict();
  end
endmodule
`default_nettype wire
